// File: hdl/port_xbar_regs.vh
`ifndef PORT_XBAR_REGS_VH
`define PORT_XBAR_REGS_VH

// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define ADDR_PORT_ZERO_LATCH   8'h80
`define ADDR_PORT_ONE_LATCH    8'h90
`define ADDR_XBAR_ROUTE_A      8'hE1
`define ADDR_XBAR_ROUTE_B      8'hE2
`define ADDR_P0_INPUT_MODE     8'hF1
`define ADDR_P1_INPUT_MODE     8'hF2
`define ADDR_P0_OUTPUT_MODE    8'hA4
`define ADDR_P1_OUTPUT_MODE    8'hA5
`define ADDR_P0_COMPARE_VALUE  8'hD3
`define ADDR_P0_COMPARE_MASK   8'hD4
`define ADDR_P1_COMPARE_VALUE  8'hCE
`define ADDR_P1_COMPARE_MASK   8'hCF
`define ADDR_EXT_IRQ_EN_TWO    8'hE7

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_PORT_LATCH         8'hFF
`define RST_XBAR_ROUTE_A       8'h00
`define RST_XBAR_ROUTE_B       8'h00
`define RST_INPUT_MODE         8'hFF
`define RST_OUTPUT_MODE        8'h00
`define RST_COMPARE_VALUE      8'h00
`define RST_COMPARE_MASK       8'h00
`define RST_EXT_IRQ_EN_TWO     8'h00

// ----------------------------------------------------------------
// field positions and writable masks
// ----------------------------------------------------------------
`define XBAR_A_WR_MASK         8'h3F
`define XBAR_B_WR_MASK         8'hFB
`define XBAR_B_WEAK_PUD_BIT    7
`define XBAR_B_ENABLE_BIT      6
`define XBAR_B_CEX_ROUTE_HI    1
`define XBAR_B_CEX_ROUTE_LO    0
`define EXT_IRQ_ENABLE_TWO_MATCH_IRQ_EN_BIT  1
`define EXT_IRQ_ENABLE_TWO_WR_MASK           8'h02
`define READ_NONE              8'h00

`endif

// File: hdl/port_pin_bank.v
`timescale 1ns/1ns
// ----------------------------------------------------------------
// eight-pin driver and receiver bank for one port
// ----------------------------------------------------------------
module port_pin_bank (
  input  wire       i_ref_clk,
  input  wire       i_rst_b,
  input  wire [7:0] i_latch,
  input  wire [7:0] i_own,
  input  wire [7:0] i_periph_dout,
  input  wire [7:0] i_input_mode,
  input  wire [7:0] i_output_mode,
  input  wire       i_xbar_en,
  input  wire       i_weak_pud,
  input  wire [7:0] i_pad_in,
  output wire [7:0] o_levels,
  output reg  [7:0] o_pad_out,
  output reg  [7:0] o_pad_oe,
  output reg  [7:0] o_pullup
);

  wire [7:0] drive_val;
  wire [7:0] digital;
  wire [7:0] nxt_oe;
  wire [7:0] nxt_out;
  wire [7:0] nxt_pullup;

  // crossbar-owned pins take the peripheral value, others the latch
  assign drive_val = (i_own & i_periph_dout) | (~i_own & i_latch);   // [RL1]
  assign digital   = i_input_mode;
  // analog pins always read as zero
  assign o_levels  = i_pad_in & digital;                              // [RL13]

  // push-pull drives both levels, open-drain only pulls low
  assign nxt_oe  = {8{i_xbar_en}} & digital &
                   (i_output_mode | ~drive_val);                      // [RL10] [RL12]
  // gated by the enable so an idle or open-drain pad never shows a stray one
  assign nxt_out = nxt_oe & i_output_mode & drive_val;                 // [RL12]
  // pull-up off while driving low, for analog and push-pull pins
  assign nxt_pullup = {8{~i_weak_pud}} & digital & ~i_output_mode &
                      ~nxt_oe;                                         // [RL11]

  // ----------------------------------------------------------------
  // registered pad controls
  // ----------------------------------------------------------------
  // pads come from flops so the pins never see decode glitches
  always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_pad_out <= 8'h00;
      o_pad_oe  <= 8'h00;
      o_pullup  <= 8'h00;
    end else begin
      o_pad_out <= nxt_out;
      o_pad_oe  <= nxt_oe;
      o_pullup  <= nxt_pullup;
    end
  end

endmodule

// File: hdl/port_crossbar_gpio_match.v
`timescale 1ns/1ns
// Contract
// [RL1] pins not given to peripherals nor analog act as plain gpio
// [RL2] both port data registers take byte writes and single-bit writes
// [RL3] a write is held in the output latch until the next write
// [RL4] an ordinary read returns the pin levels, even for routed pins
// [RL5] read-modify-write reads take the latch instead of the pins
// [RL6] match event when masked pins differ from masked compare value
// [RL7] match requests an interrupt only while its enable bit is one
// [RL8] a match event wakes the oscillator regardless of crossbar
// [RL9] match logic watches pins whatever the crossbar routing
// [RL10] crossbar disabled keeps every output driver off
// [RL11] weak pull-up on open-drain pins unless disabled, low or analog
// [RL12] latch one drives high in push-pull, floats in open-drain
// [RL13] analog-input pins read as zero, digital pins their level
// [RL14] reserved routing bits are written as zero and read as zero
// [RL15] counter-array route field selects none, one, two or three outputs
`include "port_xbar_regs.vh"

module port_crossbar_gpio_match (
  input  wire       i_ref_clk,
  input  wire       i_rst_b,
  // special function register bus
  input  wire [7:0] i_sfr_addr,
  input  wire [7:0] i_sfr_wdata,
  input  wire       i_sfr_wr,
  input  wire       i_sfr_bit_wr,
  input  wire [2:0] i_sfr_bit_sel,
  input  wire       i_sfr_bit_val,
  input  wire       i_sfr_rd,
  input  wire       i_sfr_rmw,
  output reg  [7:0] o_sfr_rdata,
  output reg        o_sfr_rd_valid,
  // priority decoder side
  input  wire [7:0] i_p0_own,
  input  wire [7:0] i_p1_own,
  input  wire [7:0] i_p0_periph_dout,
  input  wire [7:0] i_p1_periph_dout,
  output reg  [7:0] o_xbar_route_a,
  output reg  [7:0] o_xbar_route_b,
  output reg  [2:0] o_cex_route,
  // pads
  input  wire [7:0] i_p0_pad_in,
  input  wire [7:0] i_p1_pad_in,
  output wire [7:0] o_p0_pad_out,
  output wire [7:0] o_p0_pad_oe,
  output wire [7:0] o_p0_pullup,
  output wire [7:0] o_p1_pad_out,
  output wire [7:0] o_p1_pad_oe,
  output wire [7:0] o_p1_pullup,
  // match event
  output reg        o_match_event,
  output reg        o_match_irq,
  output reg        o_osc_wake
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // merged value for a byte or single-bit write
  function [7:0] write_merge;
    input [7:0] old_val;
    input [7:0] byte_val;
    input       bit_wr;
    input [2:0] bit_sel;
    input       bit_val;
    reg   [7:0] tmp;
    begin
      tmp = old_val;
      if (bit_wr) begin
        tmp[bit_sel] = bit_val;
      end else begin
        tmp = byte_val;
      end
      write_merge = tmp;
    end
  endfunction

  // mismatch between masked levels and masked compare value
  function mismatch;
    input [7:0] levels;
    input [7:0] cmp_val;
    input [7:0] mask;
    begin
      mismatch = ((levels & mask) != (cmp_val & mask));
    end
  endfunction

  // thermometer decode of the counter-array route field
  function [2:0] cex_decode;
    input [1:0] field;
    begin
      case (field)
        2'b00:   cex_decode = 3'b000;
        2'b01:   cex_decode = 3'b001;
        2'b10:   cex_decode = 3'b011;
        2'b11:   cex_decode = 3'b111;
        default: cex_decode = 3'b000;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  reg  [7:0] port_zero_latch_ff;
  reg  [7:0] port_one_latch_ff;
  reg  [7:0] route_a_ff;
  reg  [7:0] route_b_ff;
  reg  [7:0] p0_input_mode_ff;
  reg  [7:0] p1_input_mode_ff;
  reg  [7:0] p0_output_mode_ff;
  reg  [7:0] p1_output_mode_ff;
  reg  [7:0] p0_cmp_value_ff;
  reg  [7:0] p0_cmp_mask_ff;
  reg  [7:0] p1_cmp_value_ff;
  reg  [7:0] p1_cmp_mask_ff;
  reg  [7:0] ext_irq_en_two_ff;

  wire       any_wr;
  wire [7:0] p0_levels;
  wire [7:0] p1_levels;
  wire       xbar_en;
  wire       weak_pud;
  wire [7:0] p0_own;
  wire [7:0] p1_own;
  reg  [7:0] nxt_rdata;

  // bit writes only reach the bit-addressable port latches
  assign any_wr = i_sfr_wr | i_sfr_bit_wr;

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  // one process holds every writable register
  always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      port_zero_latch_ff <= `RST_PORT_LATCH;
      port_one_latch_ff  <= `RST_PORT_LATCH;
      route_a_ff         <= `RST_XBAR_ROUTE_A;
      route_b_ff         <= `RST_XBAR_ROUTE_B;
      p0_input_mode_ff   <= `RST_INPUT_MODE;
      p1_input_mode_ff   <= `RST_INPUT_MODE;
      p0_output_mode_ff  <= `RST_OUTPUT_MODE;
      p1_output_mode_ff  <= `RST_OUTPUT_MODE;
      p0_cmp_value_ff    <= `RST_COMPARE_VALUE;
      p0_cmp_mask_ff     <= `RST_COMPARE_MASK;
      p1_cmp_value_ff    <= `RST_COMPARE_VALUE;
      p1_cmp_mask_ff     <= `RST_COMPARE_MASK;
      ext_irq_en_two_ff  <= `RST_EXT_IRQ_EN_TWO;
    end else if (any_wr) begin
      case (i_sfr_addr)
        `ADDR_PORT_ZERO_LATCH: begin
          port_zero_latch_ff <= write_merge(port_zero_latch_ff, i_sfr_wdata,
                                            i_sfr_bit_wr, i_sfr_bit_sel,
                                            i_sfr_bit_val);              // [RL2] [RL3]
        end
        `ADDR_PORT_ONE_LATCH: begin
          port_one_latch_ff <= write_merge(port_one_latch_ff, i_sfr_wdata,
                                           i_sfr_bit_wr, i_sfr_bit_sel,
                                           i_sfr_bit_val);               // [RL2] [RL3]
        end
        `ADDR_XBAR_ROUTE_A: begin
          if (i_sfr_wr) begin
            route_a_ff <= i_sfr_wdata & `XBAR_A_WR_MASK;                 // [RL14]
          end
        end
        `ADDR_XBAR_ROUTE_B: begin
          if (i_sfr_wr) begin
            route_b_ff <= i_sfr_wdata & `XBAR_B_WR_MASK;                 // [RL14]
          end
        end
        `ADDR_P0_INPUT_MODE: begin
          if (i_sfr_wr) begin
            p0_input_mode_ff <= i_sfr_wdata;
          end
        end
        `ADDR_P1_INPUT_MODE: begin
          if (i_sfr_wr) begin
            p1_input_mode_ff <= i_sfr_wdata;
          end
        end
        `ADDR_P0_OUTPUT_MODE: begin
          if (i_sfr_wr) begin
            p0_output_mode_ff <= i_sfr_wdata;
          end
        end
        `ADDR_P1_OUTPUT_MODE: begin
          if (i_sfr_wr) begin
            p1_output_mode_ff <= i_sfr_wdata;
          end
        end
        `ADDR_P0_COMPARE_VALUE: begin
          if (i_sfr_wr) begin
            p0_cmp_value_ff <= i_sfr_wdata;
          end
        end
        `ADDR_P0_COMPARE_MASK: begin
          if (i_sfr_wr) begin
            p0_cmp_mask_ff <= i_sfr_wdata;
          end
        end
        `ADDR_P1_COMPARE_VALUE: begin
          if (i_sfr_wr) begin
            p1_cmp_value_ff <= i_sfr_wdata;
          end
        end
        `ADDR_P1_COMPARE_MASK: begin
          if (i_sfr_wr) begin
            p1_cmp_mask_ff <= i_sfr_wdata;
          end
        end
        `ADDR_EXT_IRQ_EN_TWO: begin
          if (i_sfr_wr) begin
            ext_irq_en_two_ff <= i_sfr_wdata & `EXT_IRQ_ENABLE_TWO_WR_MASK;
          end
        end
        default: begin
          port_zero_latch_ff <= port_zero_latch_ff;  // unmapped writes dropped
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // pins for plain reads, latch for read-modify-write operands
  always @* begin
    nxt_rdata = `READ_NONE;
    case (i_sfr_addr)
      `ADDR_PORT_ZERO_LATCH:  nxt_rdata = i_sfr_rmw ? port_zero_latch_ff : p0_levels;  // [RL4] [RL5]
      `ADDR_PORT_ONE_LATCH:   nxt_rdata = i_sfr_rmw ? port_one_latch_ff : p1_levels;   // [RL4] [RL5]
      `ADDR_XBAR_ROUTE_A:     nxt_rdata = route_a_ff;                  // [RL14]
      `ADDR_XBAR_ROUTE_B:     nxt_rdata = route_b_ff;                  // [RL14]
      `ADDR_P0_INPUT_MODE:    nxt_rdata = p0_input_mode_ff;
      `ADDR_P1_INPUT_MODE:    nxt_rdata = p1_input_mode_ff;
      `ADDR_P0_OUTPUT_MODE:   nxt_rdata = p0_output_mode_ff;
      `ADDR_P1_OUTPUT_MODE:   nxt_rdata = p1_output_mode_ff;
      `ADDR_P0_COMPARE_VALUE: nxt_rdata = p0_cmp_value_ff;
      `ADDR_P0_COMPARE_MASK:  nxt_rdata = p0_cmp_mask_ff;
      `ADDR_P1_COMPARE_VALUE: nxt_rdata = p1_cmp_value_ff;
      `ADDR_P1_COMPARE_MASK:  nxt_rdata = p1_cmp_mask_ff;
      `ADDR_EXT_IRQ_EN_TWO:   nxt_rdata = ext_irq_en_two_ff;
      default:                nxt_rdata = `READ_NONE;
    endcase
  end

  // read data held until the next read strobe
  always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_sfr_rdata    <= `READ_NONE;
      o_sfr_rd_valid <= 1'b0;
    end else begin
      o_sfr_rd_valid <= i_sfr_rd;
      if (i_sfr_rd) begin
        o_sfr_rdata <= nxt_rdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // crossbar controls
  // ----------------------------------------------------------------
  assign xbar_en  = route_b_ff[`XBAR_B_ENABLE_BIT];                   // [RL10]
  assign weak_pud = route_b_ff[`XBAR_B_WEAK_PUD_BIT];                 // [RL11]
  // analog pins are never handed over, even if the decoder asks
  assign p0_own = {8{xbar_en}} & i_p0_own & p0_input_mode_ff;          // [RL1]
  assign p1_own = {8{xbar_en}} & i_p1_own & p1_input_mode_ff;          // [RL1]

  // routing values mirrored to the priority decoder
  always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_xbar_route_a <= `RST_XBAR_ROUTE_A;
      o_xbar_route_b <= `RST_XBAR_ROUTE_B;
      o_cex_route    <= 3'b000;
    end else begin
      o_xbar_route_a <= route_a_ff;
      o_xbar_route_b <= route_b_ff;
      o_cex_route    <= cex_decode(route_b_ff[`XBAR_B_CEX_ROUTE_HI:`XBAR_B_CEX_ROUTE_LO]);  // [RL15]
    end
  end

  // ----------------------------------------------------------------
  // pin banks
  // ----------------------------------------------------------------
  port_pin_bank u_port_zero (
    .i_ref_clk     (i_ref_clk),
    .i_rst_b       (i_rst_b),
    .i_latch       (port_zero_latch_ff),
    .i_own         (p0_own),
    .i_periph_dout (i_p0_periph_dout),
    .i_input_mode  (p0_input_mode_ff),
    .i_output_mode (p0_output_mode_ff),
    .i_xbar_en     (xbar_en),
    .i_weak_pud    (weak_pud),
    .i_pad_in      (i_p0_pad_in),
    .o_levels      (p0_levels),
    .o_pad_out     (o_p0_pad_out),
    .o_pad_oe      (o_p0_pad_oe),
    .o_pullup      (o_p0_pullup)
  );

  port_pin_bank u_port_one (
    .i_ref_clk     (i_ref_clk),
    .i_rst_b       (i_rst_b),
    .i_latch       (port_one_latch_ff),
    .i_own         (p1_own),
    .i_periph_dout (i_p1_periph_dout),
    .i_input_mode  (p1_input_mode_ff),
    .i_output_mode (p1_output_mode_ff),
    .i_xbar_en     (xbar_en),
    .i_weak_pud    (weak_pud),
    .i_pad_in      (i_p1_pad_in),
    .o_levels      (p1_levels),
    .o_pad_out     (o_p1_pad_out),
    .o_pad_oe      (o_p1_pad_oe),
    .o_pullup      (o_p1_pullup)
  );

  // ----------------------------------------------------------------
  // port match
  // ----------------------------------------------------------------
  // compares pin levels, not the latch, so routed pins count too;
  // the event is a level and lasts as long as the mismatch does
  wire p0_mismatch;
  wire p1_mismatch;
  wire nxt_match;

  assign p0_mismatch = mismatch(p0_levels, p0_cmp_value_ff, p0_cmp_mask_ff);  // [RL6] [RL9]
  assign p1_mismatch = mismatch(p1_levels, p1_cmp_value_ff, p1_cmp_mask_ff);  // [RL6] [RL9]
  assign nxt_match   = p0_mismatch | p1_mismatch;                               // [RL6]

  always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_match_event <= 1'b0;
      o_match_irq   <= 1'b0;
      o_osc_wake    <= 1'b0;
    end else begin
      o_match_event <= nxt_match;
      o_match_irq   <= nxt_match & ext_irq_en_two_ff[`EXT_IRQ_ENABLE_TWO_MATCH_IRQ_EN_BIT];  // [RL7]
      o_osc_wake    <= nxt_match;                                                // [RL8]
    end
  end

endmodule

// File: verification/pad_world.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// outside world of one port: pins, far drivers, pull-ups
// ----------------------------------------------------------------
module pad_world (
  input  wire       i_ref_clk,
  input  wire [7:0] i_out,
  input  wire [7:0] i_oe,
  input  wire [7:0] i_pu,
  input  wire [7:0] i_ext_en,
  input  wire [7:0] i_ext_val,
  output wire [7:0] o_level
);
  logic [7:0] float_ff = 8'h00;

  // a pin nobody drives and nothing pulls wanders, so a stale value never passes
  always @(posedge i_ref_clk) begin
    float_ff <= ~float_ff;
  end

  // device driver wins, then the far driver, then the weak pull-up
  assign o_level = (i_oe & i_out) | (~i_oe & i_ext_en & i_ext_val) | (~i_oe & ~i_ext_en & (i_pu | float_ff));
endmodule

// File: verification/port_crossbar_gpio_match_props.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// port-level checks of routing, pads and match outputs
// ----------------------------------------------------------------
module gpio_match_props (
  input logic       i_ref_clk,
  input logic       i_rst_b,
  input logic       i_sfr_rd,
  input logic [7:0] o_sfr_rdata,
  input logic       o_sfr_rd_valid,
  input logic [7:0] o_xbar_route_a,
  input logic [7:0] o_xbar_route_b,
  input logic [2:0] o_cex_route,
  input logic [7:0] o_p0_pad_out,
  input logic [7:0] o_p0_pad_oe,
  input logic [7:0] o_p0_pullup,
  input logic [7:0] o_p1_pad_oe,
  input logic       o_match_event,
  input logic       o_match_irq,
  input logic       o_osc_wake
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);

  xbar_off_drv_a: assert property (!o_xbar_route_b[6] |-> o_p0_pad_oe == 8'h00 && o_p1_pad_oe == 8'h00)
    else $error("output driver on while crossbar is off");
  od_float_a: assert property ((o_p0_pad_out & ~o_p0_pad_oe) == 8'h00)
    else $error("pad high without its driver enabled");
  pullup_drive_a: assert property ((o_p0_pullup & o_p0_pad_oe) == 8'h00)
    else $error("pull-up on a driven pin");
  pullup_off_a: assert property (o_xbar_route_b[7] |-> o_p0_pullup == 8'h00)
    else $error("pull-up on while disabled");
  wake_event_a: assert property (o_osc_wake == o_match_event)
    else $error("wake differs from match event");
  irq_gate_a: assert property (o_match_irq |-> o_match_event)
    else $error("irq without match event");
  rsvd_zero_a: assert property (o_xbar_route_a[7:6] == 2'b00 && !o_xbar_route_b[2])
    else $error("reserved routing bit set");
  cex_therm_a: assert property (o_cex_route == {&o_xbar_route_b[1:0], o_xbar_route_b[1], |o_xbar_route_b[1:0]})
    else $error("counter-array route decode wrong");
  rd_answer_a: assert property (i_sfr_rd |=> o_sfr_rd_valid)
    else $error("read not answered next cycle");
  rd_spurious_a: assert property (o_sfr_rd_valid |-> $past(i_sfr_rd))
    else $error("read valid without read");
  rdata_hold_a: assert property (!$past(i_sfr_rd) |-> $stable(o_sfr_rdata))
    else $error("read data moved without read");
endmodule

bind port_crossbar_gpio_match gpio_match_props u_props (
  .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_sfr_rd(i_sfr_rd), .o_sfr_rdata(o_sfr_rdata),
  .o_sfr_rd_valid(o_sfr_rd_valid), .o_xbar_route_a(o_xbar_route_a), .o_xbar_route_b(o_xbar_route_b),
  .o_cex_route(o_cex_route), .o_p0_pad_out(o_p0_pad_out), .o_p0_pad_oe(o_p0_pad_oe), .o_p0_pullup(o_p0_pullup),
  .o_p1_pad_oe(o_p1_pad_oe), .o_match_event(o_match_event), .o_match_irq(o_match_irq), .o_osc_wake(o_osc_wake)
);

// File: verification/tb_port_crossbar_gpio_match.sv
`timescale 1ns/1ns
module tb_port_crossbar_gpio_match;
  logic       i_ref_clk  = 1'b0;
  logic       i_rst_b    = 1'b0;
  logic [7:0] i_sfr_addr = 8'h00;
  logic [7:0] i_sfr_wdata = 8'h00;
  logic       i_sfr_wr   = 1'b0;
  logic       i_sfr_bit_wr = 1'b0;
  logic [2:0] i_sfr_bit_sel = 3'h0;
  logic       i_sfr_bit_val = 1'b0;
  logic       i_sfr_rd   = 1'b0;
  logic       i_sfr_rmw  = 1'b0;
  logic [7:0] i_p0_own   = 8'h00;
  logic [7:0] i_p0_dout  = 8'h00;
  logic [7:0] i_p1_own   = 8'h00;
  logic [7:0] i_p1_dout  = 8'h00;
  logic [7:0] ext0_en    = 8'hFF;
  logic [7:0] ext0_val   = 8'h00;
  logic [7:0] ext1_en    = 8'hFF;
  logic [7:0] ext1_val   = 8'h00;
  wire  [7:0] o_sfr_rdata, o_xbar_route_a, o_xbar_route_b;
  wire  [7:0] p0_in, p0_out, p0_oe, p0_pu, p1_in, p1_out, p1_oe, p1_pu;
  wire  [2:0] o_cex_route;
  wire        o_sfr_rd_valid, o_match_event, o_match_irq, o_osc_wake;
  logic [7:0] exp_q[$];
  logic [7:0] ra[10] = '{8'h80, 8'h90, 8'hE1, 8'hE2, 8'hE7, 8'hF1, 8'hA4, 8'hD3, 8'hD4, 8'h00};
  logic [7:0] rv[10] = '{8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] r, d, x;
  int         miscompares = 0;
  int         total_checks = 0;
  int         cycles = 0;

  always #20 i_ref_clk = ~i_ref_clk;

  port_crossbar_gpio_match dut (
    .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_sfr_addr(i_sfr_addr), .i_sfr_wdata(i_sfr_wdata),
    .i_sfr_wr(i_sfr_wr), .i_sfr_bit_wr(i_sfr_bit_wr), .i_sfr_bit_sel(i_sfr_bit_sel), .i_sfr_bit_val(i_sfr_bit_val),
    .i_sfr_rd(i_sfr_rd), .i_sfr_rmw(i_sfr_rmw), .o_sfr_rdata(o_sfr_rdata), .o_sfr_rd_valid(o_sfr_rd_valid),
    .i_p0_own(i_p0_own), .i_p1_own(i_p1_own), .i_p0_periph_dout(i_p0_dout), .i_p1_periph_dout(i_p1_dout),
    .o_xbar_route_a(o_xbar_route_a), .o_xbar_route_b(o_xbar_route_b), .o_cex_route(o_cex_route),
    .i_p0_pad_in(p0_in), .i_p1_pad_in(p1_in), .o_p0_pad_out(p0_out), .o_p0_pad_oe(p0_oe), .o_p0_pullup(p0_pu),
    .o_p1_pad_out(p1_out), .o_p1_pad_oe(p1_oe), .o_p1_pullup(p1_pu), .o_match_event(o_match_event),
    .o_match_irq(o_match_irq), .o_osc_wake(o_osc_wake));
  pad_world pins0 (.i_ref_clk(i_ref_clk), .i_out(p0_out), .i_oe(p0_oe), .i_pu(p0_pu), .i_ext_en(ext0_en),
    .i_ext_val(ext0_val), .o_level(p0_in));
  pad_world pins1 (.i_ref_clk(i_ref_clk), .i_out(p1_out), .i_oe(p1_oe), .i_pu(p1_pu), .i_ext_en(ext1_en),
    .i_ext_val(ext1_val), .o_level(p1_in));

  // ----------------------------------------------------------------
  // bus tasks, all driving at the falling edge
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge i_ref_clk);
    i_sfr_addr = a;
    i_sfr_wdata = v;
    i_sfr_wr = 1'b1;
    @(negedge i_ref_clk);
    i_sfr_wr = 1'b0;
  endtask

  task automatic bwr(input logic [7:0] a, input logic [2:0] s, input logic v);
    @(negedge i_ref_clk);
    i_sfr_addr = a;
    i_sfr_bit_sel = s;
    i_sfr_bit_val = v;
    i_sfr_bit_wr = 1'b1;
    @(negedge i_ref_clk);
    i_sfr_bit_wr = 1'b0;
  endtask

  // expectation is queued before the strobe so the watcher always finds it
  task automatic rd(input logic [7:0] a, input logic m, input logic [7:0] exp);
    @(negedge i_ref_clk);
    exp_q.push_back(exp);
    i_sfr_addr = a;
    i_sfr_rmw = m;
    i_sfr_rd = 1'b1;
    @(negedge i_ref_clk);
    i_sfr_rd = 1'b0;
    i_sfr_rmw = 1'b0;
  endtask

  // pad or match update edge (the register edge falls inside wr), then one spare edge
  task automatic settle;
    repeat (2) @(negedge i_ref_clk);
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // read watcher and hang guard
  // ----------------------------------------------------------------
  always @(negedge i_ref_clk) begin
    if (o_sfr_rd_valid === 1'b1) begin
      check("rdata", o_sfr_rdata, exp_q.pop_front());
    end
  end

  // whole sequence needs about 120 cycles
  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      end_sim();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(98));
    repeat (8) @(negedge i_ref_clk);
    i_rst_b = 1'b1;
    // reset values, latches through the read-modify-write path, plus an unmapped hole
    foreach (ra[k]) rd(ra[k], ra[k] == 8'h80 || ra[k] == 8'h90, rv[k]);
    check("p1_pu", p1_pu, 8'hFF);
    check("p1_out", p1_out, 8'h00);
    r = $urandom;
    wr(8'hE1, r);
    rd(8'hE1, 1'b0, r & 8'h3F);
    wr(8'hE7, 8'hFF);
    rd(8'hE7, 1'b0, 8'h02);
    wr(8'hE7, 8'h00);
    check("route_a", o_xbar_route_a, r & 8'h3F);
    // latch holds byte and bit writes; rmw reads see latch not pins
    r = $urandom;
    wr(8'h80, r);
    rd(8'h80, 1'b1, r);
    bwr(8'h80, r[2:0], ~r[r[2:0]]);
    r[r[2:0]] = ~r[r[2:0]];
    rd(8'h80, 1'b1, r);
    wr(8'h90, ~r);
    rd(8'h90, 1'b1, ~r);
    // plain read returns pins; analog pins read zero
    ext0_val = $urandom;
    rd(8'h80, 1'b0, ext0_val);
    wr(8'hF1, 8'h0F);
    rd(8'h80, 1'b0, ext0_val & 8'h0F);
    wr(8'hF1, 8'hFF);
    // crossbar on, push-pull, port 0 low nibble and all of port 1 owned by a peripheral
    ext0_en = 8'h00;
    d = $urandom;
    i_p0_own = 8'h0F;
    i_p0_dout = d;
    i_p1_own = 8'hFF;
    i_p1_dout = d;
    x = (d & 8'h0F) | (r & 8'hF0);
    wr(8'hE2, 8'h40);
    wr(8'hA4, 8'hFF);
    wr(8'hA5, 8'hFF);
    settle();
    check("p0_oe", p0_oe, 8'hFF);
    check("p0_out", p0_out, x);
    check("p1_out", p1_out, d);
    rd(8'h80, 1'b0, x);
    // open-drain: ones float with pull-up, zeros drive low
    wr(8'hA4, 8'h00);
    settle();
    check("p0_oe", p0_oe, ~x);
    check("p0_pu", p0_pu, x);
    wr(8'hE2, 8'hC0);
    settle();
    check("p0_pu", p0_pu, 8'h00);
    wr(8'hE2, 8'h00);
    settle();
    check("oe_off", p0_oe | p1_oe, 8'h00);
    // match on either port, irq gated by its enable
    ext0_en = 8'hFF;
    ext0_val = 8'h00;
    ext1_val = 8'h80;
    wr(8'hCF, 8'h80);
    wr(8'hCE, 8'h80);
    wr(8'hD4, 8'h01);
    settle();
    check("match", {5'h0, o_match_event, o_match_irq, o_osc_wake}, 8'h00);
    ext0_val = 8'hFE;
    settle();
    check("match", {5'h0, o_match_event, o_match_irq, o_osc_wake}, 8'h00);
    ext0_val = 8'h01;
    settle();
    check("match", {5'h0, o_match_event, o_match_irq, o_osc_wake}, 8'h05);
    wr(8'hE7, 8'h02);
    settle();
    check("match", {5'h0, o_match_event, o_match_irq, o_osc_wake}, 8'h07);
    ext0_val = 8'h00;
    ext1_val = 8'h7F;
    settle();
    check("match", {5'h0, o_match_event, o_match_irq, o_osc_wake}, 8'h07);
    // counter-array route codes, then reserved bit refused
    for (int k = 0; k < 4; k++) begin
      wr(8'hE2, k[7:0]);
      settle();
      check("cex", {5'h0, o_cex_route}, (8'h01 << k) - 8'h01);
    end
    wr(8'hE2, 8'hBF);
    rd(8'hE2, 1'b0, 8'hBB);
    settle();
    check("route_b", o_xbar_route_b, 8'hBB);
    check("pending", 8'(exp_q.size()), 8'h00);
    end_sim();
  end
endmodule
